// >>> rtl/mlc_nand_page_read_decode.sv
// What this block does
// - Override bit zero written 0 holds chip enable active; 1 returns control; resets 0.
// - On release, controller keeps sequencing and drops chip enable when idle.
// - Normal decode passes flash bytes to the CPU while checking them.
// - After a single-symbol error in the last 255 bytes the serial buffer holds the corrected page bytes; uncorrectable errors are left in place.
// - Parity write may be skipped when 528 bytes are read directly.
// - Start-auto-decode makes controller fetch the page, decode it, set ready.
// - Spare read command 0x50 goes to the flash as main read 0x00.
// - Enabled ECC-ready event fires when a normal decode completes without a parity write.
// - Enabled error event fires after a decode that found or failed errors.
// - Enabled controller-ready event fires when an auto decode completes.
// - Status bit 0 follows ready/busy, held clear for busy time after transfers.
// - Controller ready clears when a parity or auto cycle starts, sets at end.
// - Status bit 2 sets when decoding of the current cycle completes.
// - Bit 3 flags errors, bit 6 uncorrectable, bits 5:4 always read zero.
`timescale 1ns/10ps
`default_nettype none
module mlc_nand_page_read_decode #(
    parameter logic [7:0] WB_CYCLES = mlc_read_pkg::WB_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [31:0] reg_rdata_o,
    output logic             flash_cle_o,
    output logic             flash_ale_o,
    output logic             flash_we_n_o,
    output logic             flash_re_n_o,
    output logic             flash_chip_enable_n_o,
    output logic      [7:0]  flash_data_o,
    output logic             flash_data_oe_n_o,
    input  wire logic [7:0]  flash_data_i,
    input  wire logic        flash_ready_i,
    output logic             ecc_ready_evt_o,
    output logic             error_evt_o,
    output logic             ctrl_ready_evt_o
);
    import mlc_read_pkg::*;

    if (WB_CYCLES < 8'h08) begin : g_bad_wb
        $error("WB_CYCLES below 8 cannot cover the flash busy delay");
    end

    // Pin synchronisers: first stages feed only the second stages
    logic [7:0] data_m_q, data_s_q;
    logic       rdy_m_q, rdy_s_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_m_q <= 8'h00;
            data_s_q <= 8'h00;
            rdy_m_q  <= 1'b0;
            rdy_s_q  <= 1'b0;
        end else begin
            data_m_q <= flash_data_i;
            data_s_q <= data_m_q;
            rdy_m_q  <= flash_ready_i;
            rdy_s_q  <= rdy_m_q;
        end
    end

    // Register decode
    wire hit_cmd   = reg_addr_i == OFS_CMD;
    wire hit_addr  = reg_addr_i == OFS_ADDR;
    wire hit_data  = reg_addr_i == OFS_DATA;
    wire hit_buf   = reg_addr_i == OFS_BUF;
    wire hit_evt   = reg_addr_i == OFS_EVT_EN;
    wire hit_stat  = reg_addr_i == OFS_STATUS;
    wire wr_cmd    = reg_we_i && hit_cmd;
    wire wr_addr   = reg_we_i && hit_addr;
    wire wr_start  = reg_we_i && reg_addr_i == OFS_START_DEC;
    wire wr_parity = reg_we_i && reg_addr_i == OFS_RD_PARITY;
    wire wr_auto   = reg_we_i && reg_addr_i == OFS_AUTO_DEC;
    wire wr_evt    = reg_we_i && hit_evt;
    wire wr_ce     = reg_we_i && reg_addr_i == OFS_CE_OVR;
    wire rd_data   = reg_re_i && hit_data;
    wire rd_buf    = reg_re_i && hit_buf;

    eng_state_t eng_q;
    op_t        op_q;
    dec_state_t dec_q;
    logic [7:0] tcnt_q, dout_q, byte_q, wb_q, t_q;
    logic [9:0] cnt_q, rptr_q, pos_q;
    logic       pend_q, ce_normal_q, spare_q, ctrl_flow_q;
    logic       ctrl_rdy_q, ecc_rdy_q, err_q, fail_q;
    logic [2:0] evt_en_q;
    logic [7:0] buf_q [0:527];
    logic [7:0] s0, s1;

    // Engine: CPU command/address writes win over byte fetches; a write while busy is dropped
    wire eng_idle  = eng_q == E_IDLE;
    wire go_cpu    = eng_idle && (wr_cmd || wr_addr);
    wire go_fetch  = eng_idle && !wr_cmd && !wr_addr && pend_q;
    wire byte_done = eng_q == E_LOW && tcnt_q == 8'h00 && op_q == OP_READ;
    wire xfer_end  = eng_q == E_HIGH && tcnt_q == 8'h00;
    wire fetching  = dec_q == D_DIRECT || dec_q == D_FETCH;
    wire store_en  = byte_done && fetching && cnt_q < PAGE_BYTES;
    wire dec_idle  = dec_q == D_IDLE;
    wire start_any = dec_idle && (wr_start || wr_auto);
    wire auto_req  = dec_q == D_FETCH && eng_idle && !pend_q && cnt_q < PAGE_BYTES;
    // Spare reads need the whole page for the decoder, so the main read goes out
    wire [7:0] cmd_out = reg_wdata_i[7:0] == CMD_READ_SPARE ? CMD_READ_MAIN : reg_wdata_i[7:0];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eng_q  <= E_IDLE;
            op_q   <= OP_CMD;
            tcnt_q <= 8'h00;
            dout_q <= 8'h00;
        end else begin
            case (eng_q)
                E_IDLE: begin
                    if (go_cpu) begin
                        eng_q  <= E_LOW;
                        op_q   <= wr_cmd ? OP_CMD : OP_ADDR;
                        dout_q <= wr_cmd ? cmd_out : reg_wdata_i[7:0];
                        tcnt_q <= STROBE_CYC - 8'h01;
                    end else if (go_fetch) begin
                        eng_q  <= E_LOW;
                        op_q   <= OP_READ;
                        tcnt_q <= STROBE_CYC - 8'h01;
                    end
                end
                E_LOW: begin
                    tcnt_q <= tcnt_q - 8'h01;
                    if (tcnt_q == 8'h00) begin
                        eng_q  <= E_HIGH;
                        tcnt_q <= HOLD_CYC - 8'h01;
                    end
                end
                E_HIGH: begin
                    tcnt_q <= tcnt_q - 8'h01;
                    if (tcnt_q == 8'h00) begin
                        eng_q <= E_IDLE;
                    end
                end
                default: eng_q <= E_IDLE;
            endcase
        end
    end

    // Pins follow the engine one cycle late; chip enable held low by override or activity
    wire busy_any = !eng_idle || !dec_idle || pend_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flash_cle_o           <= 1'b0;
            flash_ale_o           <= 1'b0;
            flash_we_n_o          <= 1'b1;
            flash_re_n_o          <= 1'b1;
            flash_data_oe_n_o     <= 1'b1;
            flash_data_o          <= 8'h00;
            flash_chip_enable_n_o <= 1'b1;
        end else begin
            flash_cle_o           <= !eng_idle && op_q == OP_CMD;
            flash_ale_o           <= !eng_idle && op_q == OP_ADDR;
            flash_we_n_o          <= !(eng_q == E_LOW && op_q != OP_READ);
            flash_re_n_o          <= !(eng_q == E_LOW && op_q == OP_READ);
            flash_data_oe_n_o     <= eng_idle || op_q == OP_READ;
            flash_data_o          <= dout_q;
            flash_chip_enable_n_o <= ce_normal_q ? !busy_any : 1'b0;
        end
    end

    // Busy hold after each transfer keeps the ready flag from reporting too early
    wire nand_rdy = rdy_s_q && eng_idle && wb_q == 8'h00;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_q <= 8'h00;
        end else if (xfer_end) begin
            wb_q <= WB_CYCLES;
        end else if (wb_q != 8'h00) begin
            wb_q <= wb_q - 8'h01;
        end
    end

    rs_syndrome u_syn (
        .clk_i    (core_clk_i),
        .arst_n_i (arst_n_i),
        .clear_i  (start_any),
        .valid_i  (store_en),
        .byte_i   (data_s_q),
        .s0_o     (s0),
        .s1_o     (s1)
    );

    // Decode outcomes; search walks positions from the last byte, t tracks s0*alpha^k
    wire clean     = dec_q == D_CHECK && s0 == 8'h00 && s1 == 8'h00;
    wire multi     = dec_q == D_CHECK && s0 == 8'h00 && s1 != 8'h00;
    wire hit       = dec_q == D_SEARCH && t_q == s1;
    wire miss      = dec_q == D_SEARCH && !hit && pos_q == 10'h000;
    wire done_err  = hit;
    wire done_fail = multi || miss;
    wire done_any  = clean || done_err || done_fail;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dec_q       <= D_IDLE;
            cnt_q       <= 10'h000;
            pos_q       <= 10'h000;
            t_q         <= 8'h00;
            pend_q      <= 1'b0;
            ctrl_flow_q <= 1'b0;
        end else begin
            // A new request beats the hand-over to the engine, so no read is lost
            if (rd_data || auto_req || (dec_idle && wr_start)) begin
                pend_q <= 1'b1;
            end else if (go_fetch) begin
                pend_q <= 1'b0;
            end
            if (store_en) begin
                cnt_q <= cnt_q + 10'h001;
            end
            case (dec_q)
                D_IDLE: begin
                    cnt_q       <= 10'h000;
                    ctrl_flow_q <= wr_auto;
                    if (wr_start) begin
                        dec_q <= D_DIRECT;
                    end else if (wr_auto) begin
                        dec_q <= D_FETCH;
                    end
                end
                D_DIRECT: begin
                    if (cnt_q == PAGE_BYTES) begin
                        dec_q <= D_CHECK;
                    end else if (wr_parity) begin
                        dec_q       <= D_FETCH;
                        ctrl_flow_q <= 1'b1;
                    end
                end
                D_FETCH: begin
                    if (cnt_q == PAGE_BYTES) begin
                        dec_q <= D_CHECK;
                    end
                end
                D_CHECK: begin
                    t_q   <= s0;
                    pos_q <= PAGE_BYTES - 10'h001;
                    dec_q <= (clean || multi) ? D_IDLE : D_SEARCH;
                end
                D_SEARCH: begin
                    t_q   <= gf_mul_alpha(t_q);
                    pos_q <= pos_q - 10'h001;
                    if (hit || miss) begin
                        dec_q <= D_IDLE;
                    end
                end
                default: dec_q <= D_IDLE;
            endcase
        end
    end

    // Page buffer: fetched bytes land in order, a located error is fixed in place
    // Limitation: one symbol corrected, and positions alias every 255 bytes
    always_ff @(posedge core_clk_i) begin
        if (store_en) begin
            buf_q[cnt_q] <= data_s_q;
        end else if (hit) begin
            buf_q[pos_q] <= buf_q[pos_q] ^ s0;
        end
    end

    // Status flags: start clears, completion sets; the two never coincide
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_rdy_q <= 1'b0;
            ecc_rdy_q  <= 1'b0;
            err_q      <= 1'b0;
            fail_q     <= 1'b0;
        end else if (start_any || (dec_q == D_DIRECT && wr_parity)) begin
            ctrl_rdy_q <= ctrl_rdy_q && !wr_auto && !wr_parity;
            ecc_rdy_q  <= ecc_rdy_q && !start_any;
            err_q      <= err_q && !start_any;
            fail_q     <= fail_q && !start_any;
        end else if (done_any) begin
            ctrl_rdy_q <= ctrl_rdy_q || ctrl_flow_q;
            ecc_rdy_q  <= 1'b1;
            err_q      <= !clean;
            fail_q     <= done_fail;
        end
    end

    // Control registers, read pointer, data byte and events
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ce_normal_q      <= CE_OVR_RESET;
            evt_en_q         <= EVT_EN_RESET;
            spare_q          <= 1'b0;
            rptr_q           <= 10'h000;
            byte_q           <= 8'h00;
            ecc_ready_evt_o  <= 1'b0;
            error_evt_o      <= 1'b0;
            ctrl_ready_evt_o <= 1'b0;
        end else begin
            if (wr_ce) begin
                ce_normal_q <= reg_wdata_i[CE_NORMAL_BIT];
            end
            if (wr_evt) begin
                evt_en_q <= reg_wdata_i[2:0];
            end
            if (go_cpu && wr_cmd) begin
                spare_q <= reg_wdata_i[7:0] == CMD_READ_SPARE;
            end
            if (start_any) begin
                rptr_q <= spare_q ? SPARE_START : 10'h000;
            end else if (rd_buf && rptr_q < PAGE_BYTES) begin
                rptr_q <= rptr_q + 10'h001;
            end
            if (byte_done) begin
                byte_q <= data_s_q;
            end
            ecc_ready_evt_o  <= done_any && !ctrl_flow_q && evt_en_q[EN_ECC];
            error_evt_o      <= (done_err || done_fail) && evt_en_q[EN_ERR];
            ctrl_ready_evt_o <= done_any && ctrl_flow_q && evt_en_q[EN_CTRL];
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    wire [6:0]  status  = {fail_q, 2'b00, err_q, ecc_rdy_q, ctrl_rdy_q, nand_rdy};
    wire [7:0]  buf_rd  = rptr_q < PAGE_BYTES ? buf_q[rptr_q] : 8'h00;
    wire [31:0] rdata_d = hit_stat ? {25'h0000000, status} :
                          hit_data ? {24'h000000, byte_q} :
                          hit_buf  ? {24'h000000, buf_rd} :
                          hit_evt  ? {29'h00000000, evt_en_q} : 32'h00000000;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_rdata_o <= reg_re_i ? rdata_d : 32'h00000000;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_ce_forced_low: assert property (!ce_normal_q |=> !flash_chip_enable_n_o)
        else $error("chip enable not held by override");
    a_ce_release_busy: assert property (ce_normal_q && !eng_idle |=> !flash_chip_enable_n_o)
        else $error("chip enable dropped during a transfer");
    a_ce_release_idle: assert property (ce_normal_q && !busy_any |=> flash_chip_enable_n_o)
        else $error("chip enable kept after release with nothing to do");
    a_direct_data: assert property (rd_data |=> reg_rdata_o[7:0] == $past(byte_q))
        else $error("direct read did not return the fetched byte");
    a_buf_store: assert property (store_en ##1 !hit |-> buf_q[$past(cnt_q)] == $past(data_s_q))
        else $error("fetched byte not stored in page buffer");
    a_parity_gather: assert property (dec_q == D_DIRECT && cnt_q == PAGE_BYTES |=> dec_q == D_CHECK)
        else $error("full direct read did not start the check");
    a_auto_start: assert property (wr_auto && dec_idle |=> dec_q == D_FETCH && !ctrl_rdy_q)
        else $error("auto decode did not start");
    a_spare_subst: assert property (go_cpu && wr_cmd && reg_wdata_i[7:0] == CMD_READ_SPARE
                                    |=> dout_q == CMD_READ_MAIN ##1 flash_data_o == CMD_READ_MAIN)
        else $error("spare read command not substituted");
    a_ecc_event: assert property (done_any && !ctrl_flow_q && evt_en_q[EN_ECC] |=> ecc_ready_evt_o)
        else $error("missing ECC ready event");
    a_error_event: assert property (done_fail && evt_en_q[EN_ERR] |=> error_evt_o && fail_q)
        else $error("missing error event");
    a_ctrl_event: assert property (done_any && ctrl_flow_q |=> ctrl_rdy_q
                                   && (ctrl_ready_evt_o == $past(evt_en_q[EN_CTRL])))
        else $error("controller ready not reported");
    a_nand_busy: assert property (xfer_end |=> !status[ST_NAND_RDY] [*8])
        else $error("ready flag rose within busy time");
    a_ecc_ready: assert property (done_any |=> ecc_rdy_q ##0 (err_q == !$past(clean)))
        else $error("ECC ready or error flag wrong after decode");
    a_fail_flag: assert property (fail_q |-> err_q && status[5:4] == 2'b00)
        else $error("failure flag without error flag");
    a_new_cycle: assert property (start_any |=> !ecc_rdy_q && !err_q && !fail_q)
        else $error("stale flags survived a new decode");
endmodule
`default_nettype wire

// >>> rtl/mlc_read_pkg.sv
package mlc_read_pkg;
    // Register byte addresses on the plain register port
    localparam logic [31:0] OFS_CMD       = 32'h200b8000;
    localparam logic [31:0] OFS_ADDR      = 32'h200b8004;
    localparam logic [31:0] OFS_DATA      = 32'h200b8008;
    localparam logic [31:0] OFS_START_DEC = 32'h200b800c;
    localparam logic [31:0] OFS_RD_PARITY = 32'h200b8010;
    localparam logic [31:0] OFS_AUTO_DEC  = 32'h200b8014;
    localparam logic [31:0] OFS_BUF       = 32'h200b8018;
    localparam logic [31:0] OFS_EVT_EN    = 32'h200b801c;
    localparam logic [31:0] OFS_STATUS    = 32'h200b8048;
    localparam logic [31:0] OFS_CE_OVR    = 32'h200b804c;

    // Field positions and reset values
    localparam int         CE_NORMAL_BIT = 0;
    localparam logic       CE_OVR_RESET  = 1'b0;
    localparam int         ST_NAND_RDY   = 0;
    localparam int         ST_CTRL_RDY   = 1;
    localparam int         ST_ECC_RDY    = 2;
    localparam int         ST_ERR        = 3;
    localparam int         ST_FAIL       = 6;
    localparam int         EN_ECC        = 0;
    localparam int         EN_ERR        = 1;
    localparam int         EN_CTRL       = 2;
    localparam logic [2:0] EVT_EN_RESET  = 3'h0;

    // Flash commands and page geometry
    localparam logic [7:0] CMD_READ_MAIN  = 8'h00;
    localparam logic [7:0] CMD_READ_SPARE = 8'h50;
    localparam logic [9:0] DATA_BYTES     = 10'h206;
    localparam logic [9:0] PAGE_BYTES     = 10'h210;
    localparam logic [9:0] SPARE_START    = 10'h200;

    // Timing: figures in ns, counts rounded up to whole 4 ns cycles
    localparam int         CLK_NS      = 4;
    localparam int         T_WB_NS     = 100;
    localparam int         T_STROBE_NS = 40;
    localparam int         T_HOLD_NS   = 12;
    localparam logic [7:0] WB_CYC      = 8'((T_WB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] STROBE_CYC  = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC    = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {E_IDLE = 2'h0, E_LOW = 2'h1, E_HIGH = 2'h3} eng_state_t;
    typedef enum logic [1:0] {OP_CMD = 2'h0, OP_ADDR = 2'h1, OP_READ = 2'h2} op_t;
    typedef enum logic [2:0] {
        D_IDLE = 3'h0, D_DIRECT = 3'h1, D_FETCH = 3'h3, D_CHECK = 3'h2, D_SEARCH = 3'h6
    } dec_state_t;

    // Multiply by the field generator, polynomial x^8+x^4+x^3+x^2+1
    function automatic logic [7:0] gf_mul_alpha(input logic [7:0] v);
        return {v[6:0], 1'b0} ^ (v[7] ? 8'h1d : 8'h00);
    endfunction
endpackage

// >>> rtl/rs_syndrome.sv
`timescale 1ns/10ps
`default_nettype none
module rs_syndrome (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       clear_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] byte_i,
    output logic      [7:0] s0_o,
    output logic      [7:0] s1_o
);
    import mlc_read_pkg::*;

    // Two syndromes: plain sum and Horner sum weighted by powers of the generator
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s0_o <= 8'h00;
            s1_o <= 8'h00;
        end else if (clear_i) begin
            s0_o <= 8'h00;
            s1_o <= 8'h00;
        end else if (valid_i) begin
            s0_o <= s0_o ^ byte_i;
            s1_o <= gf_mul_alpha(s1_o) ^ byte_i;
        end
    end
endmodule
`default_nettype wire

// >>> tb/nand_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module nand_flash_model (
    input  wire logic       clk_i,
    input  wire logic       cle_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic [7:0] cmd_i,
    input  wire logic [9:0] err_pos_i,
    input  wire logic [7:0] err_val_i,
    output logic      [7:0] data_o,
    output logic            ready_o,
    output logic      [7:0] last_cmd_o
);
    logic [9:0] cnt_q  = 10'h0;
    logic [7:0] busy_q = 8'h0;
    logic [7:0] last_q = 8'h0;
    logic       we_q   = 1'b1;
    logic       re_q   = 1'b1;
    // An all-zero page is a valid codeword; one injected byte makes a single-symbol error
    assign data_o  = re_n_i ? ~last_q : ((cnt_q == err_pos_i) ? err_val_i : 8'h00);
    assign ready_o = (busy_q == 8'h0);
    // Latch commands on the strobe rise and go busy a while, as a real part does
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        re_q <= re_n_i;
        if (!we_q && we_n_i && cle_i) begin
            last_cmd_o <= cmd_i;
            cnt_q      <= 10'h0;
            busy_q     <= 8'h14;
        end else if (busy_q != 8'h0) begin
            busy_q <= busy_q - 8'h1;
        end
        if (!re_q && re_n_i) begin
            cnt_q <= cnt_q + 10'h1;
        end
        if (!re_n_i) begin
            last_q <= data_o;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import mlc_read_pkg::*;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, we = 1'b0, re = 1'b0, cle, ale, we_n, re_n, ce_n, oe_n, rdy;
    logic ecc_e, err_e, ctl_e, ecc_s = 1'b0, err_s = 1'b0, ctl_s = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, v;
    logic [7:0]  dout, din, lcmd, eval = 8'h5a;
    logic [9:0]  epos = 10'h203;
    int          miscompares = 0, cmp_count = 0, cyc = 0;
    mlc_nand_page_read_decode #(.WB_CYCLES(8'h08)) uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .flash_cle_o(cle), .flash_ale_o(ale), .flash_we_n_o(we_n), .flash_re_n_o(re_n),
        .flash_chip_enable_n_o(ce_n), .flash_data_o(dout), .flash_data_oe_n_o(oe_n),
        .flash_data_i(din), .flash_ready_i(rdy), .ecc_ready_evt_o(ecc_e), .error_evt_o(err_e),
        .ctrl_ready_evt_o(ctl_e));
    nand_flash_model flash (.clk_i(core_clk_i), .cle_i(cle), .we_n_i(we_n), .re_n_i(re_n), .cmd_i(dout),
        .err_pos_i(epos), .err_val_i(eval), .data_o(din), .ready_o(rdy), .last_cmd_o(lcmd));
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    // Events are single-cycle pulses, so they are caught in sticky flags
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (ecc_e === 1'b1) ecc_s <= 1'b1;
        if (err_e === 1'b1) err_s <= 1'b1;
        if (ctl_e === 1'b1) ctl_s <= 1'b1;
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i) begin we <= 1'b1; addr <= a; wdata <= d; end
        @(posedge core_clk_i) we <= 1'b0;
        repeat (20) @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge core_clk_i) begin re <= 1'b1; addr <= a; end
        @(posedge core_clk_i) re <= 1'b0;
        #1 v = rdata;
    endtask
    // Software side of a page read: command, optional read start, address, wait ready
    task automatic open_page(input logic [7:0] c, input logic big);
        wr(OFS_CMD, {24'h0, c});
        if (big) wr(OFS_CMD, 32'h30);
        wr(OFS_ADDR, 32'h0);
        v = 32'h0;
        for (int n = 0; n < 100 && v[0] !== 1'b1; n++) rd(OFS_STATUS);
        chk(v[ST_NAND_RDY], 1'b1);
        ecc_s = 1'b0; err_s = 1'b0; ctl_s = 1'b0;
    endtask
    task automatic wait_evt();
        for (int n = 0; n < 12000 && !(ecc_s | ctl_s); n++) @(negedge core_clk_i);
        repeat (4) @(negedge core_clk_i);
    endtask
    // Spare read through auto decode, single-symbol error in the spare bytes
    task automatic t_spare_auto();
        open_page(CMD_READ_SPARE, 1'b0);
        chk(lcmd, 32'h00);
        wr(OFS_AUTO_DEC, 32'h1);
        rd(OFS_STATUS);
        chk(v[ST_CTRL_RDY], 1'b0);
        wait_evt();
        chk({ctl_s, err_s, ecc_s}, 3'h6);
        rd(OFS_STATUS);
        chk(v[6:1], 6'h07);
        for (int k = 0; k < 16; k++) begin
            rd(OFS_BUF);
            chk(v, 32'h0);
        end
    endtask
    // Large-block normal decode, 528 direct reads with no parity write
    task automatic t_normal_direct();
        epos = 10'h007; eval = 8'h81;
        open_page(CMD_READ_MAIN, 1'b1);
        chk(lcmd, 32'h30);
        wr(OFS_START_DEC, 32'h1);
        rd(OFS_STATUS);
        chk(v[3:2], 2'h0);
        for (int k = 0; k < 528; k++) begin
            rd(OFS_DATA);
            chk(v, (k == 7) ? 32'h81 : 32'h0);
            repeat (14) @(posedge core_clk_i);
        end
        wait_evt();
        chk({ctl_s, err_s, ecc_s}, 3'h3);
        rd(OFS_STATUS);
        chk(v[6:2], 5'h03);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk(ce_n, 1'b0);
        rd(OFS_CE_OVR);
        chk(v, 32'h0);
        wr(OFS_EVT_EN, 32'h7);
        t_spare_auto();
        t_normal_direct();
        wr(OFS_CE_OVR, 32'h1);
        chk(ce_n, 1'b1);
        wr(OFS_CE_OVR, 32'h0);
        chk(ce_n, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
